// file: verilog/nid_core.sv
// nibble cpu core: instruction decode, execute and apb register slave
// Function
// - add uses opcodes 00000 and 10000
// - add with carry 00010/10010 includes carry
// - subtract 00001/10001, with borrow 00011/10011
// - or, and, xor both operand forms
// - sub-ops 1001/1000 increment address, index
// - bit tests clear compare, skip on match
// - compares subtract immediate, skip, store nothing
// - load, store, indirect column from register
// - table read loads data buffer, two cycles
// - push and pop address register on stack
// - window register to and from register file
// - data buffer to and from peripheral space
// - direct branch loads 11-bit target, page bit
// - call pushes return address, jumps to target
// - returns pop pc, skip or restore saved
// - interrupt enable flag set or cleared
// - stop, halt with release nibble, plain nop
// - compare flag blocks arithmetic result write
// - carry flag follows addition carry out
// - zero flag clears on nonzero, compare-held
// - binary or decimal arithmetic by rp bit RP_BCD
// - index register ors into memory address
// - index holds pointer enable, bank, row, column
`timescale 1ns/10ps
module nid_core (
  input wire logic clock, // system clock
  input wire logic rst, // asynchronous reset
  input wire logic ce, // clock enable
  input wire logic [7:0] paddr, // apb address
  input wire logic psel, // apb select
  input wire logic penable, // apb enable
  input wire logic pwrite, // apb direction
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error
  output logic [11:0] progAddr, // program memory address
  input wire logic [15:0] progData, // program word at progAddr
  input wire logic [3:0] wake, // release events
  input wire logic [15:0] periphRdData, // peripheral read data
  output nid_pkg::nid_pbus_s periph // peripheral request
);
  import nid_pkg::*;

  logic [3:0] dmem [0:DMEM_D-1];
  logic [3:0] rfile [0:RF_D-1];
  logic [11:0] stack [0:STACK_D-1];

  nid_state_e state_r, state_nxt;
  logic [11:0] pc_r, pc_nxt, progAddr_r, progAddr_nxt;
  logic [11:0] ar_r, ar_nxt, ix_r, ix_nxt;
  logic [15:0] dbf_r, dbf_nxt;
  logic [2:0] sp_r, sp_nxt, mp_r, mp_nxt;
  logic [7:0] rp_r, rp_nxt;
  logic [3:0] wr_r, wr_nxt, interrupt_stack_r, interrupt_stack_nxt, relCond_r, relCond_nxt;
  logic run_r, run_nxt, ixe_r, ixe_nxt, cmp_r, cmp_nxt;
  logic cy_r, cy_nxt, z_r, z_nxt, interrupt_enable_flag_r, interrupt_enable_flag_nxt, skip_r, skip_nxt;
  logic [31:0] prdata_r, prdata_nxt;
  logic pready_r, pready_nxt, pslverr_r, pslverr_nxt;
  nid_pbus_s periph_r, periph_nxt;

  nid_instr_s ins;
  logic [6:0] memAddr, regAddr, indAddr, dWa, rfAddr;
  logic [3:0] mVal, rVal, aluA, aluB, aluRes, dWd;
  logic [4:0] sum5, diff5, cmpDiff;
  logic [3:0] aluOp;
  logic dWe, rfWe, stkWe, isAlu, isArith, cin, carry, bcd;
  logic [2:0] stkWa;
  logic [11:0] stkWd, pcInc;
  logic [31:0] rdMux;
  logic mapped, setup, access;

  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign progAddr = progAddr_r;
  assign periph = periph_r;

  always_comb begin
    ins = nid_instr_s'(progData);
    // pointer-enable in the index top bit, then bank, row, column
    memAddr = {ins.row, ins.col};
    if (ixe_r) begin
      memAddr = memAddr | ix_r[6:0];
    end
    regAddr = {rp_r[RP_ROW_LSB +: 3], ins.nib};
    mVal = dmem[memAddr];
    rVal = dmem[regAddr];
    indAddr = {(ix_r[IX_MPE] ? mp_r : ins.row), rVal};
    rfAddr = {ins.row, ins.nib};
    bcd = rp_r[RP_BCD];
    aluOp = ins.op[3:0];
    isAlu = !ins.op[3] && (ins.op[2:0] != 3'h7);
    isArith = isAlu && (aluOp <= ALU_SUBTRACT_WITH_BORROW);
    aluA = ins.op[OP_FORM_BIT] ? mVal : rVal;
    aluB = ins.op[OP_FORM_BIT] ? ins.nib : mVal;
    cin = ((aluOp == ALU_ADD_WITH_CARRY) || (aluOp == ALU_SUBTRACT_WITH_BORROW)) && cy_r;
    sum5 = {1'b0, aluA} + {1'b0, aluB} + {4'h0, cin};
    diff5 = {1'b0, aluA} - {1'b0, aluB} - {4'h0, cin};
    cmpDiff = {1'b0, mVal} - {1'b0, ins.nib};
    aluRes = 4'h0;
    carry = 1'b0;
    case (aluOp)
      ALU_ADD, ALU_ADD_WITH_CARRY: begin
        if (bcd && (sum5 > BCD_MAX)) begin
          aluRes = 4'(sum5 + BCD_ADJ);
          carry = 1'b1;
        end else begin
          aluRes = sum5[3:0];
          carry = sum5[4];
        end
      end
      ALU_SUB, ALU_SUBTRACT_WITH_BORROW: begin
        carry = diff5[4];
        aluRes = (bcd && diff5[4]) ? 4'(diff5 - BCD_ADJ) : diff5[3:0];
      end
      ALU_AND: aluRes = aluA & aluB;
      ALU_XOR: aluRes = aluA ^ aluB;
      ALU_OR: aluRes = aluA | aluB;
      default: aluRes = 4'h0;
    endcase
    pcInc = pc_r + 12'h001;

    state_nxt = state_r;
    pc_nxt = pc_r;
    progAddr_nxt = progAddr_r;
    ar_nxt = ar_r;
    ix_nxt = ix_r;
    dbf_nxt = dbf_r;
    sp_nxt = sp_r;
    mp_nxt = mp_r;
    rp_nxt = rp_r;
    wr_nxt = wr_r;
    interrupt_stack_nxt = interrupt_stack_r;
    relCond_nxt = relCond_r;
    run_nxt = run_r;
    ixe_nxt = ixe_r;
    cmp_nxt = cmp_r;
    cy_nxt = cy_r;
    z_nxt = z_r;
    interrupt_enable_flag_nxt = interrupt_enable_flag_r;
    skip_nxt = skip_r;
    periph_nxt = periph_r;
    periph_nxt.wr = 1'b0;
    periph_nxt.rd = 1'b0;
    dWe = 1'b0;
    dWa = memAddr;
    dWd = 4'h0;
    rfWe = 1'b0;
    stkWe = 1'b0;
    stkWa = sp_r - 3'h1;
    stkWd = pcInc;

    case (state_r)
      ST_EXEC: begin
        if (run_r && skip_r) begin
          skip_nxt = 1'b0;
          pc_nxt = pcInc;
        end else if (run_r && isAlu) begin
          pc_nxt = pcInc;
          dWa = ins.op[OP_FORM_BIT] ? memAddr : regAddr;
          dWd = aluRes;
          dWe = !(isArith && cmp_r);
          if (isArith) begin
            cy_nxt = carry;
            if (aluRes != 4'h0) begin
              z_nxt = 1'b0;
            end else if (!cmp_r) begin
              z_nxt = 1'b1;
            end
          end
        end else if (run_r) begin
          pc_nxt = pcInc;
          case (ins.op)
            OP_LOAD: begin
              dWa = regAddr;
              dWd = mVal;
              dWe = 1'b1;
            end
            OP_STORE: begin
              dWd = rVal;
              dWe = 1'b1;
            end
            OP_MOV_IND_TO: begin
              dWa = indAddr;
              dWd = mVal;
              dWe = 1'b1;
            end
            OP_MOV_IND_FROM: begin
              dWd = dmem[indAddr];
              dWe = 1'b1;
            end
            OP_MOV_IMM: begin
              dWd = ins.nib;
              dWe = 1'b1;
            end
            OP_SKIP_EQ: skip_nxt = (cmpDiff[3:0] == 4'h0);
            OP_SKIP_NE: skip_nxt = (cmpDiff[3:0] != 4'h0);
            OP_SKIP_GE: skip_nxt = !cmpDiff[4];
            OP_SKIP_LT: skip_nxt = cmpDiff[4];
            OP_SKIP_BSET: begin
              cmp_nxt = 1'b0;
              skip_nxt = ((mVal & ins.nib) == ins.nib);
            end
            OP_SKIP_BCLR: begin
              cmp_nxt = 1'b0;
              skip_nxt = ((mVal & ins.nib) == 4'h0);
            end
            OP_BRANCH_P0: pc_nxt = {1'b0, progData[10:0]};
            OP_BRANCH_P1: pc_nxt = {1'b1, progData[10:0]};
            OP_CALL: begin
              stkWe = 1'b1;
              sp_nxt = sp_r - 3'h1;
              pc_nxt = {1'b0, progData[10:0]};
            end
            OP_MISC: begin
              case (ins.col)
                SUB_INC_AR: ar_nxt = ar_r + 12'h001;
                SUB_INC_IX: ix_nxt = ix_r + 12'h001;
                SUB_TABLE: begin
                  stkWe = 1'b1;
                  sp_nxt = sp_r - 3'h1;
                  pc_nxt = pc_r;
                  state_nxt = ST_TABLE;
                end
                SUB_PUSH_AR: begin
                  stkWe = 1'b1;
                  stkWd = ar_r;
                  sp_nxt = sp_r - 3'h1;
                end
                SUB_POP_AR: begin
                  ar_nxt = stack[sp_r];
                  sp_nxt = sp_r + 3'h1;
                end
                SUB_RF_READ: wr_nxt = rfile[rfAddr];
                SUB_RF_WRITE: rfWe = 1'b1;
                SUB_PERIPH_GET: begin
                  periph_nxt.addr = rfAddr;
                  periph_nxt.rd = 1'b1;
                  pc_nxt = pc_r;
                  state_nxt = ST_PERIPH;
                end
                SUB_PERIPH_PUT: begin
                  periph_nxt.addr = rfAddr;
                  periph_nxt.wdata = dbf_r;
                  periph_nxt.wr = 1'b1;
                end
                SUB_BRANCH_AR: pc_nxt = ar_r;
                SUB_CALL_AR: begin
                  stkWe = 1'b1;
                  sp_nxt = sp_r - 3'h1;
                  pc_nxt = ar_r;
                end
                SUB_ROTATE: begin
                  dWa = regAddr;
                  dWd = {cy_r, rVal[3:1]};
                  dWe = 1'b1;
                  cy_nxt = rVal[0];
                end
                SUB_RETURN: begin
                  pc_nxt = stack[sp_r];
                  sp_nxt = sp_r + 3'h1;
                  skip_nxt = (ins.row == ROW_RET_SKIP);
                  if (ins.row == ROW_RET_INT) begin
                    cy_nxt = interrupt_stack_r[INTERRUPT_STACK_CY];
                    z_nxt = interrupt_stack_r[INTERRUPT_STACK_Z];
                    cmp_nxt = interrupt_stack_r[INTERRUPT_STACK_CMP];
                    ixe_nxt = interrupt_stack_r[INTERRUPT_STACK_IXE];
                  end
                end
                SUB_SYSTEM: begin
                  case (ins.row)
                    ROW_INT_EN: interrupt_enable_flag_nxt = 1'b1;
                    ROW_INT_DIS: interrupt_enable_flag_nxt = 1'b0;
                    ROW_STOP, ROW_HALT: begin
                      relCond_nxt = ins.nib;
                      state_nxt = ST_SLEEP;
                    end
                    default: pc_nxt = pcInc;
                  endcase
                end
                default: pc_nxt = pcInc;
              endcase
            end
            default: pc_nxt = pcInc;
          endcase
        end
      end
      ST_TABLE: begin
        dbf_nxt = progData;
        pc_nxt = stack[sp_r];
        sp_nxt = sp_r + 3'h1;
        state_nxt = ST_EXEC;
      end
      ST_PERIPH: begin
        dbf_nxt = periphRdData;
        pc_nxt = pcInc;
        state_nxt = ST_EXEC;
      end
      default: begin
        // pc already points past the sleep instruction
        if (((wake & relCond_r) != 4'h0) || !run_r) begin
          state_nxt = ST_EXEC;
        end
      end
    endcase
    progAddr_nxt = (state_nxt == ST_TABLE) ? ar_r : pc_nxt;

    // apb slave: read data captured in setup, one access cycle
    setup = psel && !penable;
    access = psel && penable && pready_r;
    rdMux = 32'h0;
    mapped = 1'b1;
    if (paddr == ADDR_CTRL) begin
      rdMux[CTRL_RUN] = run_r;
      rdMux[CTRL_IXE] = ixe_r;
      rdMux[CTRL_CMP] = cmp_r;
      rdMux[CTRL_MP_LSB +: 3] = mp_r;
    end else if (paddr == ADDR_RP) begin
      rdMux[7:0] = rp_r;
    end else if (paddr == ADDR_IX) begin
      rdMux[11:0] = ix_r;
    end else if (paddr == ADDR_STATUS) begin
      rdMux[STAT_PC_LSB +: 12] = pc_r;
      rdMux[STAT_CY] = cy_r;
      rdMux[STAT_Z] = z_r;
      rdMux[STAT_INTERRUPT_ENABLE_FLAG] = interrupt_enable_flag_r;
      rdMux[STAT_SLEEP] = (state_r == ST_SLEEP);
      rdMux[STAT_SP_LSB +: 3] = sp_r;
    end else if (paddr == ADDR_AR) begin
      rdMux[11:0] = ar_r;
    end else if (paddr == ADDR_DBF) begin
      rdMux[15:0] = dbf_r;
    end else if (paddr == ADDR_INTERRUPT_STACK) begin
      rdMux[3:0] = interrupt_stack_r;
    end else begin
      mapped = 1'b0;
    end
    pready_nxt = setup;
    pslverr_nxt = setup && !mapped;
    prdata_nxt = (setup && !pwrite) ? rdMux : 32'h0;
    if (access && pwrite) begin
      if (paddr == ADDR_CTRL) begin
        run_nxt = pwdata[CTRL_RUN];
        ixe_nxt = pwdata[CTRL_IXE];
        cmp_nxt = pwdata[CTRL_CMP]; // software write wins
        mp_nxt = pwdata[CTRL_MP_LSB +: 3];
      end else if (paddr == ADDR_RP) begin
        rp_nxt = pwdata[7:0];
      end else if (paddr == ADDR_IX) begin
        ix_nxt = pwdata[11:0];
      end else if (paddr == ADDR_AR) begin
        ar_nxt = pwdata[11:0];
      end else if (paddr == ADDR_DBF) begin
        dbf_nxt = pwdata[15:0];
      end else if (paddr == ADDR_INTERRUPT_STACK) begin
        interrupt_stack_nxt = pwdata[3:0];
      end
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state_r <= ST_EXEC;
      pc_r <= PC_RST;
      progAddr_r <= PC_RST;
      ar_r <= AR_RST;
      ix_r <= IX_RST;
      dbf_r <= DBF_RST;
      sp_r <= SP_RST;
      mp_r <= MP_RST;
      rp_r <= RP_RST;
      wr_r <= 4'h0;
      interrupt_stack_r <= INTERRUPT_STACK_RST;
      relCond_r <= 4'h0;
      run_r <= 1'b0;
      ixe_r <= 1'b0;
      cmp_r <= 1'b0;
      cy_r <= 1'b0;
      z_r <= 1'b0;
      interrupt_enable_flag_r <= 1'b0;
      skip_r <= 1'b0;
      prdata_r <= 32'h0;
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      periph_r <= '0;
    end else if (ce) begin
      state_r <= state_nxt;
      pc_r <= pc_nxt;
      progAddr_r <= progAddr_nxt;
      ar_r <= ar_nxt;
      ix_r <= ix_nxt;
      dbf_r <= dbf_nxt;
      sp_r <= sp_nxt;
      mp_r <= mp_nxt;
      rp_r <= rp_nxt;
      wr_r <= wr_nxt;
      interrupt_stack_r <= interrupt_stack_nxt;
      relCond_r <= relCond_nxt;
      run_r <= run_nxt;
      ixe_r <= ixe_nxt;
      cmp_r <= cmp_nxt;
      cy_r <= cy_nxt;
      z_r <= z_nxt;
      interrupt_enable_flag_r <= interrupt_enable_flag_nxt;
      skip_r <= skip_nxt;
      prdata_r <= prdata_nxt;
      pready_r <= pready_nxt;
      pslverr_r <= pslverr_nxt;
      periph_r <= periph_nxt;
    end
  end

  always_ff @(posedge clock) begin
    if (ce && dWe) begin
      dmem[dWa] <= dWd;
    end
    if (ce && rfWe) begin
      rfile[rfAddr] <= wr_r;
    end
    if (ce && stkWe) begin
      stack[stkWa] <= stkWd;
    end
  end
endmodule

// file: verilog/nid_pkg.sv
// constants, types and register map of the nibble instruction decoder
package nid_pkg;
  localparam int PC_W = 12;
  localparam int DBF_W = 16;
  localparam int SP_W = 3;
  localparam int STACK_D = 8;
  localparam int DMEM_D = 128;
  localparam int RF_D = 128;
  // opcode field values
  localparam logic [4:0] OP_MISC = 5'h07;
  localparam logic [4:0] OP_LOAD = 5'h08;
  localparam logic [4:0] OP_SKIP_EQ = 5'h09;
  localparam logic [4:0] OP_MOV_IND_TO = 5'h0a;
  localparam logic [4:0] OP_SKIP_NE = 5'h0b;
  localparam logic [4:0] OP_BRANCH_P0 = 5'h0c;
  localparam logic [4:0] OP_BRANCH_P1 = 5'h0d;
  localparam logic [4:0] OP_STORE = 5'h18;
  localparam logic [4:0] OP_SKIP_GE = 5'h19;
  localparam logic [4:0] OP_MOV_IND_FROM = 5'h1a;
  localparam logic [4:0] OP_SKIP_LT = 5'h1b;
  localparam logic [4:0] OP_CALL = 5'h1c;
  localparam logic [4:0] OP_MOV_IMM = 5'h1d;
  localparam logic [4:0] OP_SKIP_BSET = 5'h1e;
  localparam logic [4:0] OP_SKIP_BCLR = 5'h1f;
  // low four opcode bits of the alu group; bit 4 picks the immediate form
  localparam int OP_FORM_BIT = 4;
  localparam logic [3:0] ALU_ADD = 4'h0;
  localparam logic [3:0] ALU_SUB = 4'h1;
  localparam logic [3:0] ALU_ADD_WITH_CARRY = 4'h2;
  localparam logic [3:0] ALU_SUBTRACT_WITH_BORROW = 4'h3;
  localparam logic [3:0] ALU_AND = 4'h4;
  localparam logic [3:0] ALU_XOR = 4'h5;
  localparam logic [3:0] ALU_OR = 4'h6;
  // sub-op values under OP_MISC
  localparam logic [3:0] SUB_TABLE = 4'h1;
  localparam logic [3:0] SUB_RF_WRITE = 4'h2;
  localparam logic [3:0] SUB_RF_READ = 4'h3;
  localparam logic [3:0] SUB_BRANCH_AR = 4'h4;
  localparam logic [3:0] SUB_CALL_AR = 4'h5;
  localparam logic [3:0] SUB_ROTATE = 4'h7;
  localparam logic [3:0] SUB_INC_IX = 4'h8;
  localparam logic [3:0] SUB_INC_AR = 4'h9;
  localparam logic [3:0] SUB_PERIPH_PUT = 4'ha;
  localparam logic [3:0] SUB_PERIPH_GET = 4'hb;
  localparam logic [3:0] SUB_POP_AR = 4'hc;
  localparam logic [3:0] SUB_PUSH_AR = 4'hd;
  localparam logic [3:0] SUB_RETURN = 4'he;
  localparam logic [3:0] SUB_SYSTEM = 4'hf;
  localparam logic [2:0] ROW_RET = 3'h0;
  localparam logic [2:0] ROW_RET_SKIP = 3'h1;
  localparam logic [2:0] ROW_RET_INT = 3'h4;
  localparam logic [2:0] ROW_INT_EN = 3'h0;
  localparam logic [2:0] ROW_INT_DIS = 3'h1;
  localparam logic [2:0] ROW_STOP = 3'h2;
  localparam logic [2:0] ROW_HALT = 3'h3;
  localparam logic [2:0] ROW_NOP = 3'h4;
  localparam logic [4:0] BCD_MAX = 5'h09;
  localparam logic [4:0] BCD_ADJ = 5'h06;
  // register byte addresses
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_RP = 8'h04;
  localparam logic [7:0] ADDR_IX = 8'h08;
  localparam logic [7:0] ADDR_STATUS = 8'h0c;
  localparam logic [7:0] ADDR_AR = 8'h10;
  localparam logic [7:0] ADDR_DBF = 8'h14;
  localparam logic [7:0] ADDR_INTERRUPT_STACK = 8'h18;
  // field positions
  localparam int CTRL_RUN = 0;
  localparam int CTRL_IXE = 1;
  localparam int CTRL_CMP = 2;
  localparam int CTRL_MP_LSB = 4;
  localparam int RP_BCD = 0;
  localparam int RP_ROW_LSB = 1;
  localparam int IX_MPE = 11;
  localparam int STAT_PC_LSB = 0;
  localparam int STAT_CY = 12;
  localparam int STAT_Z = 13;
  localparam int STAT_INTERRUPT_ENABLE_FLAG = 14;
  localparam int STAT_SLEEP = 15;
  localparam int STAT_SP_LSB = 16;
  localparam int INTERRUPT_STACK_CY = 0;
  localparam int INTERRUPT_STACK_Z = 1;
  localparam int INTERRUPT_STACK_CMP = 2;
  localparam int INTERRUPT_STACK_IXE = 3;
  // reset values
  localparam logic [7:0] RP_RST = 8'h00;
  localparam logic [11:0] IX_RST = 12'h000;
  localparam logic [11:0] AR_RST = 12'h000;
  localparam logic [15:0] DBF_RST = 16'h0000;
  localparam logic [11:0] PC_RST = 12'h000;
  localparam logic [2:0] SP_RST = 3'h0;
  localparam logic [2:0] MP_RST = 3'h0;
  localparam logic [3:0] INTERRUPT_STACK_RST = 4'h0;

  typedef struct packed {
    logic [4:0] op;
    logic [2:0] row;
    logic [3:0] col;
    logic [3:0] nib;
  } nid_instr_s;

  typedef struct packed {
    logic [6:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
  } nid_pbus_s;

  typedef enum logic [1:0] {
    ST_EXEC = 2'b00,
    ST_TABLE = 2'b01,
    ST_PERIPH = 2'b10,
    ST_SLEEP = 2'b11
  } nid_state_e;
endpackage

// file: testbench/nid_core_checker.sv
// port assertions for the nibble core
`timescale 1ns/10ps
module nid_core_checker import nid_pkg::*; (
  input wire logic clock, // system clock
  input wire logic rst, // async reset
  input wire logic ce, // clock enable
  input wire logic [7:0] paddr, // apb address
  input wire logic psel, // apb select
  input wire logic penable, // apb enable
  input wire logic [31:0] prdata, // apb read data
  input wire logic pready, // apb ready
  input wire logic pslverr, // apb error
  input wire logic [11:0] progAddr, // fetch address
  input wire logic [15:0] progData, // fetched word
  input wire nid_pkg::nid_pbus_s periph // peripheral request
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  logic [15:0] prevWord;
  logic setupQ;
  always_ff @(posedge clock) begin
    prevWord <= progData;
    setupQ <= psel && !penable;
  end
  property p_rdy; psel && !penable |=> pready; endproperty
  a_rdy: assert property (p_rdy) else $error("no ready after setup");
  property p_once; pready |=> !pready; endproperty
  a_once: assert property (p_once) else $error("ready held too long");
  property p_cause; pready |-> setupQ; endproperty
  a_cause: assert property (p_cause) else $error("ready without setup");
  property p_err; pslverr |-> pready; endproperty
  a_err: assert property (p_err) else $error("error without ready");
  property p_unmap;
    psel && !penable && paddr > ADDR_INTERRUPT_STACK |=> pslverr && prdata == 32'h0;
  endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped not refused");
  property p_put;
    $rose(periph.wr) |-> prevWord[15:11] == OP_MISC &&
      prevWord[7:4] == SUB_PERIPH_PUT &&
      periph.addr == {prevWord[10:8], prevWord[3:0]};
  endproperty
  a_put: assert property (p_put) else $error("bad put");
  property p_get;
    $rose(periph.rd) |-> prevWord[15:11] == OP_MISC &&
      prevWord[7:4] == SUB_PERIPH_GET &&
      periph.addr == {prevWord[10:8], prevWord[3:0]};
  endproperty
  a_get: assert property (p_get) else $error("bad get");
  property p_excl; !(periph.wr && periph.rd); endproperty
  a_excl: assert property (p_excl) else $error("rd and wr");
  property p_wrpulse; periph.wr && ce |=> !periph.wr; endproperty
  a_wrpulse: assert property (p_wrpulse) else $error("long put");
  property p_freeze; !ce |=> $stable(progAddr) && $stable(periph); endproperty
  a_freeze: assert property (p_freeze) else $error("moved while frozen");
  c_put: cover property (periph.wr);
  c_get: cover property (periph.rd);
  c_err: cover property (pslverr);
endmodule
bind nid_core nid_core_checker chk (.clock(clock), .rst(rst), .ce(ce),
  .paddr(paddr), .psel(psel), .penable(penable), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .progAddr(progAddr),
  .progData(progData), .periph(periph));

// file: testbench/nid_prog_mem.sv
// program memory and peripheral space facing the core
`timescale 1ns/10ps
module nid_prog_mem import nid_pkg::*; (
  input wire logic clock, // system clock
  input wire logic rst, // async reset
  input wire logic [11:0] progAddr, // fetch address
  output logic [15:0] progData, // fetched word
  input wire nid_pkg::nid_pbus_s periph, // peripheral request
  output logic [15:0] periphRdData, // peripheral read data
  output logic [6:0] putAddr, // last put address
  output logic [15:0] putData // last put data
);
  logic [15:0] rom [0:4095];
  logic [15:0] lastRd;
  logic held;
  function automatic logic [15:0] rdVal(input logic [6:0] a);
    return {9'h0, a} ^ 16'hc3a5;
  endfunction
  // unused words decode as no-operation
  initial begin
    for (int i = 0; i < 4096; i++) begin
      rom[i] = 16'h3cf0;
    end
  end
  assign progData = rom[progAddr];
  // outside a read the data lines hold the last read value for one cycle, then show its inverse
  assign periphRdData = periph.rd ? rdVal(periph.addr) :
    held ? lastRd : ~lastRd;
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      held <= 1'b0;
      lastRd <= 16'h0;
      putAddr <= 7'h0;
      putData <= 16'h0;
    end else begin
      held <= periph.rd;
      if (periph.rd) begin
        lastRd <= rdVal(periph.addr);
      end
      if (periph.wr) begin
        putAddr <= periph.addr;
        putData <= periph.wdata;
      end
    end
  end
endmodule

// file: testbench/nid_core_bench.sv
// self-checking bench for the nibble core
`timescale 1ns/10ps
module nid_core_bench import nid_pkg::*;;
  localparam logic [15:0] INC_AR = 16'h3890;
  localparam logic [15:0] INC_IX = 16'h3880;
  logic clock, rst, ce, psel, penable, pwrite, pready, pslverr, err;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [11:0] progAddr;
  logic [15:0] progData, periphRdData, putData;
  logic [6:0] putAddr;
  logic [3:0] wake;
  nid_pbus_s periph;
  int error_cnt, total_checks;
  logic [15:0] q[$];
  nid_core dut (.clock(clock), .rst(rst), .ce(ce), .paddr(paddr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .progAddr(progAddr), .progData(progData), .wake(wake),
    .periphRdData(periphRdData), .periph(periph));
  nid_prog_mem pm (.clock(clock), .rst(rst), .progAddr(progAddr),
    .progData(progData), .periph(periph), .periphRdData(periphRdData),
    .putAddr(putAddr), .putData(putData));
  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end
  task automatic end_of_test();
    if (error_cnt == 0 && total_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    total_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("mismatch %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic apb(input logic [7:0] a, input logic w,
                     input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clock);
    psel <= 1'b1;
    penable <= 1'b0;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    do begin
      @(posedge clock);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (n >= 16) begin
      chk(32'h0, 32'h1);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic reset_core();
    rst <= 1'b1;
    repeat (6) @(posedge clock);
    rst <= 1'b0;
  endtask
  // load program, preset one register, start, freeze briefly, let it finish
  task automatic run(input logic [7:0] pa, input logic [31:0] pv,
                     input logic [31:0] ctrl);
    foreach (q[i]) pm.rom[i] = q[i];
    reset_core();
    apb(pa, 1'b1, pv);
    apb(ADDR_CTRL, 1'b1, ctrl);
    ce <= 1'b0;
    repeat (4) @(posedge clock);
    ce <= 1'b1;
    repeat (40) @(posedge clock);
  endtask
  initial begin
    repeat (20000) @(posedge clock);
    error_cnt++;
    end_of_test();
  end
  initial begin
    rst = 1'b1;
    ce = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h0;
    pwdata = 32'h0;
    wake = 4'h0;
    reset_core();
    for (int a = 0; a <= 28; a += 4) begin
      apb(8'(a), 1'b0, 32'h0);
      chk(rd, 32'h0);
      chk(32'(err), 32'(a == 28));
    end
    apb(ADDR_STATUS, 1'b1, 32'hffffffff);
    apb(ADDR_STATUS, 1'b0, 32'h0);
    chk(rd, 32'h0);
    // carry out, then equal compare skips the first increment
    q = '{16'hea19, 16'h8218, 16'h4a11, INC_AR, INC_AR, 16'h6005};
    run(ADDR_IX, 32'h0, 32'h1);
    apb(ADDR_STATUS, 1'b0, 32'h0);
    chk(rd, 32'h1005);
    apb(ADDR_AR, 1'b0, 32'h0);
    chk(rd, 32'h1);
    // compare flag set: sum not stored, zero held, bit test clears it
    q = '{16'hea17, 16'h8219, 16'hf217, INC_AR, INC_IX, 16'h6005};
    run(ADDR_IX, 32'h0, 32'h5);
    apb(ADDR_CTRL, 1'b0, 32'h0);
    chk(rd, 32'h1);
    apb(ADDR_STATUS, 1'b0, 32'h0);
    chk(rd, 32'h1005);
    apb(ADDR_AR, 1'b0, 32'h0);
    chk(rd, 32'h0);
    apb(ADDR_IX, 1'b0, 32'h0);
    chk(rd, 32'h1);
    // decimal add then add with carry
    q = '{16'he858, 16'he865, 16'h0065, 16'h1065, 16'h4859, INC_AR,
          16'h6006};
    run(ADDR_RP, 32'h1, 32'h1);
    apb(ADDR_RP, 1'b0, 32'h0);
    chk(rd, 32'h1);
    apb(ADDR_STATUS, 1'b0, 32'h0);
    chk(rd, 32'h0006);
    apb(ADDR_AR, 1'b0, 32'h0);
    chk(rd, 32'h0);
    // subtract, logic ops, load/store and every compare kind
    q = '{16'he903, 16'h8905, 16'h490e, INC_AR, 16'hb101, 16'ha106,
          16'ha903, 16'h4100, 16'hc300, 16'h4b05, INC_AR, 16'h5b05,
          INC_AR, 16'hdb06, INC_IX, 16'hcb06, INC_IX, 16'hfb0a, INC_AR,
          16'h6013};
    run(ADDR_IX, 32'h0, 32'h1);
    apb(ADDR_STATUS, 1'b0, 32'h0);
    chk(rd, 32'h1013);
    apb(ADDR_AR, 1'b0, 32'h0);
    chk(rd, 32'h1);
    apb(ADDR_IX, 1'b0, 32'h0);
    chk(rd, 32'h1);
    // stack, table read, put, call/skip return, enable, get, halt
    pm.rom[24] = 16'h39e0;
    pm.rom[32] = 16'h5a3c;
    q = '{16'h38d0, 16'h3810, 16'h39a2, INC_AR, 16'h38c0, 16'he018,
          INC_AR, 16'h38f0, 16'h3bb4, 16'h3bf1, 16'h39f0, 16'h600b};
    run(ADDR_AR, 32'h20, 32'h1);
    apb(ADDR_AR, 1'b0, 32'h0);
    chk(rd, 32'h20);
    apb(ADDR_DBF, 1'b0, 32'h0);
    chk(rd, 32'hc391);
    chk({9'h0, putAddr, putData}, 32'h125a3c);
    apb(ADDR_STATUS, 1'b0, 32'h0);
    chk(rd & 32'h7f000, 32'h0c000);
    wake <= 4'h1;
    repeat (20) @(posedge clock);
    wake <= 4'h0;
    apb(ADDR_STATUS, 1'b0, 32'h0);
    chk(rd, 32'h0000000b);
    end_of_test();
  end
endmodule
